// ===== dsw_defines.vh
`ifndef DSW_DEFINES_VH
`define DSW_DEFINES_VH
// counter and reload figures
`define DSW_CNT_W 16
`define DSW_RELOAD_MIN 16'h0064
`define DSW_RELOAD_DEFAULT 16'h1388
// fault codes
`define DSW_FAULT_NONE 2'h0
`define DSW_FAULT_BG 2'h1
`define DSW_FAULT_FG 2'h2
// toggle supervision: more than 40 toggles per second, i.e. gap under 25 ms
`define DSW_CLK_HZ 20000000
`define DSW_TOGGLE_MAX_MS 25
`define DSW_TOGGLE_CYCLES ((`DSW_CLK_HZ / 1000) * `DSW_TOGGLE_MAX_MS)
// power-up window for seeing a clock interrupt, in microseconds
`define DSW_CLKWAIT_US 1000
`define DSW_CLKWAIT_CYCLES ((`DSW_CLK_HZ / 1000000) * `DSW_CLKWAIT_US)
`endif

// ===== dsw_sync.v
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser for a pin
module dsw_sync
(
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire din,
    output reg dout
);
    reg stage1;

    // first stage feeds only the second
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end
        else if (ce)
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule // dsw_sync

// ===== dsw_hw_stage.v
`timescale 1ns/1ps
`include "dsw_defines.vh"
// ==========================================================
// hardware stage: trips on slow toggle or low supply
module dsw_hw_stage
#(
    parameter TOGGLE_CYCLES = `DSW_TOGGLE_CYCLES
)
(
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire enable,
    input wire toggle_in,
    input wire undervolt,
    output reg trip
);
    reg last_toggle;
    reg [31:0] gap;

    // gap counter restarts on every edge of the toggle input
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_toggle <= 1'b0;
            gap <= 32'h0000_0000;
            trip <= 1'b0;
        end
        else if (ce)
        begin
            last_toggle <= toggle_in;
            if (!enable || toggle_in != last_toggle)
                gap <= 32'h0000_0000; // a disabled stage starts timing afresh
            else if (gap < TOGGLE_CYCLES)
                gap <= gap + 32'h0000_0001;
            if (enable && (undervolt || gap >= TOGGLE_CYCLES))
                trip <= 1'b1;
        end
    end
endmodule // dsw_hw_stage

// ===== dsw_supervisor.v
`timescale 1ns/1ps
`include "dsw_defines.vh"
// Contract
// - the hardware stage trips unless its toggle input changes more than 40 times a second; the code does not time the toggle in stay-alive mode.
// - the hardware stage trips hard whenever the undervoltage indication is active; the code ignores undervoltage while a soft trip is latched.
// - each real-time interrupt decrements the counter only while above zero, and its lsb is the toggle; the code reloads instead on a same-cycle cycle end.
// - each background cycle end reloads the counter, using 5000 when the setting is below 100.
// - a counter seen at zero causes a soft trip with fault code 1.
// - the set number of background cycles with no interrupt between causes a soft trip with code 2.
// - a soft trip kills motors, aborts motion and holds interface hardware reset, cpu keeps running.
// - a soft trip disables the hardware stage so it cannot shut the processor down.
// - a soft trip stays latched until reset command, re-init command or power cycle.
// - no clock interrupt at power-up gives stay-alive mode with the no-clock flag and motors barred.
// - clocks lost after being present lead to a soft trip, not stay-alive mode.
// - a hard trip holds interface hardware reset and shuts the processor down.
// - a hard trip de-energises the relay, opening the normally-open contact.
// - a hard trip clears only at power cycle, never by command.
module dsw_supervisor
#(
    parameter CNT_W = `DSW_CNT_W,
    parameter TOGGLE_CYCLES = `DSW_TOGGLE_CYCLES,
    parameter CLKWAIT_CYCLES = `DSW_CLKWAIT_CYCLES
)
(
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire rti_pulse,
    input wire bg_cycle_end,
    input wire clock_irq,
    input wire reset_cmd,
    input wire reinit_cmd,
    input wire undervolt_pin,
    input wire [CNT_W-1:0] counter_reload_value,
    input wire [7:0] max_cycles_without_interrupt,
    output reg [1:0] soft_trip_fault_code,
    output reg no_clock_flag,
    output reg soft_trip,
    output reg hard_trip,
    output reg motion_abort,
    output reg motor_kill,
    output reg motor_enable_allowed,
    output reg iface_reset,
    output reg cpu_shutdown,
    output reg relay_energised,
    output reg wd_toggle,
    output reg [CNT_W-1:0] service_count
);
    // ==========================================================
    // state
    localparam ST_WAIT = 2'b00;
    localparam ST_RUN = 2'b01;
    localparam ST_ALIVE = 2'b10;

    reg [1:0] state;
    reg [31:0] wait_cnt;
    reg [7:0] bg_count;
    reg hw_enable;
    reg [CNT_W-1:0] next_count;

    // next values of the registered state
    reg [1:0] next_state;
    reg [31:0] next_wait_cnt;
    reg next_no_clock_flag;
    reg next_soft_trip;
    reg [1:0] next_soft_trip_fault_code;
    reg next_hw_enable;

    // next values of the safety outputs
    reg next_motion_abort;
    reg next_motor_kill;
    reg next_motor_enable_allowed;
    reg next_iface_reset;
    reg next_cpu_shutdown;
    reg next_relay_energised;
    wire hw_stage_en;
    wire undervolt;
    wire hw_trip;
    wire clear_cmd;
    wire bg_fail;
    wire fg_fail;

    assign clear_cmd = reset_cmd | reinit_cmd;

    // stay-alive has no interrupts to toggle, so toggle timing rests there
    assign hw_stage_en = hw_enable && (state != ST_ALIVE);

    // undervoltage comes from a comparator pin
    dsw_sync u_uv_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .din(undervolt_pin),
        .dout(undervolt)
    );

    // hardware stage watches the counter lsb
    dsw_hw_stage #(.TOGGLE_CYCLES(TOGGLE_CYCLES)) u_hw
    (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .enable(hw_stage_en),
        .toggle_in(wd_toggle),
        .undervolt(undervolt),
        .trip(hw_trip)
    );

    // ==========================================================
    // service counter next value
    always @*
    begin
        next_count = service_count;
        if (bg_cycle_end)
        begin
            if (counter_reload_value < `DSW_RELOAD_MIN)
                next_count = `DSW_RELOAD_DEFAULT;
            else
                next_count = counter_reload_value;
        end
        else if (rti_pulse && service_count != {CNT_W{1'b0}})
            next_count = service_count - {{(CNT_W-1){1'b0}}, 1'b1};
    end

    // fault detection only while running with clocks
    assign bg_fail = (state == ST_RUN) && (service_count == {CNT_W{1'b0}});
    assign fg_fail = (state == ST_RUN) && bg_cycle_end && !rti_pulse &&
                     (max_cycles_without_interrupt != 8'h00) &&
                     (bg_count + 8'h01 >= max_cycles_without_interrupt);

    // ==========================================================
    // counter, background-cycle count and toggle
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            service_count <= `DSW_RELOAD_DEFAULT;
            wd_toggle <= 1'b0;
            bg_count <= 8'h00;
        end
        else if (ce)
        begin
            service_count <= next_count;
            wd_toggle <= next_count[0];
            if (rti_pulse)
                bg_count <= 8'h00;
            else if (bg_cycle_end && bg_count != 8'hff)
                bg_count <= bg_count + 8'h01;
        end
    end

    // ==========================================================
    // power-up clock detection: next state
    always @*
    begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        next_no_clock_flag = no_clock_flag;
        case (state)
            ST_WAIT:
            begin
                if (clock_irq)
                    next_state = ST_RUN;
                else if (wait_cnt >= CLKWAIT_CYCLES)
                begin
                    next_state = ST_ALIVE;
                    next_no_clock_flag = 1'b1;
                end
                else
                    next_wait_cnt = wait_cnt + 32'h0000_0001;
            end
            // lost clocks show up as a stalled counter, not as a state change
            ST_RUN:
                next_state = ST_RUN;
            ST_ALIVE:
            begin
                if (clear_cmd)
                begin
                    next_state = ST_WAIT;
                    next_wait_cnt = 32'h0000_0000;
                    next_no_clock_flag = 1'b0;
                end
            end
            default:
            begin
                next_state = ST_WAIT;
                next_wait_cnt = 32'h0000_0000;
                next_no_clock_flag = 1'b0;
            end
        endcase
    end

    // power-up clock detection: state registers
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_WAIT;
            wait_cnt <= 32'h0000_0000;
            no_clock_flag <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            no_clock_flag <= next_no_clock_flag;
        end
    end

    // ==========================================================
    // soft trip latch and fault code: a new fault beats a clear
    always @*
    begin
        next_soft_trip = soft_trip;
        next_soft_trip_fault_code = soft_trip_fault_code;
        next_hw_enable = hw_enable;
        if (bg_fail && !soft_trip)
        begin
            next_soft_trip = 1'b1;
            next_soft_trip_fault_code = `DSW_FAULT_BG;
            next_hw_enable = 1'b0;
        end
        else if (fg_fail && !soft_trip)
        begin
            next_soft_trip = 1'b1;
            next_soft_trip_fault_code = `DSW_FAULT_FG;
            next_hw_enable = 1'b0;
        end
        else if (clear_cmd && !bg_fail && !fg_fail)
        begin
            next_soft_trip = 1'b0;
            next_soft_trip_fault_code = `DSW_FAULT_NONE;
            next_hw_enable = 1'b1;
        end
    end

    // soft trip registers
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            soft_trip <= 1'b0;
            soft_trip_fault_code <= `DSW_FAULT_NONE;
            hw_enable <= 1'b1;
        end
        else if (ce)
        begin
            soft_trip <= next_soft_trip;
            soft_trip_fault_code <= next_soft_trip_fault_code;
            hw_enable <= next_hw_enable;
        end
    end

    // ==========================================================
    // hard trip latch: only power-on reset clears it
    // undervoltage is taken here directly so it also trips in stay-alive mode
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hard_trip <= 1'b0;
        else if (ce && (hw_trip || undervolt) && hw_enable)
            hard_trip <= 1'b1;
    end

    // ==========================================================
    // safety outputs: next values
    always @*
    begin
        next_motion_abort = soft_trip | hard_trip;
        next_motor_kill = soft_trip | hard_trip | (state != ST_RUN);
        next_motor_enable_allowed = !soft_trip && !hard_trip && (state == ST_RUN);
        next_iface_reset = soft_trip | hard_trip | (state == ST_WAIT);
        next_cpu_shutdown = hard_trip;
        next_relay_energised = !hard_trip;
    end

    // safety output registers
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            motion_abort <= 1'b0;
            motor_kill <= 1'b1;
            motor_enable_allowed <= 1'b0;
            iface_reset <= 1'b1;
            cpu_shutdown <= 1'b0;
            relay_energised <= 1'b0;
        end
        else if (ce)
        begin
            motion_abort <= next_motion_abort;
            motor_kill <= next_motor_kill;
            motor_enable_allowed <= next_motor_enable_allowed;
            iface_reset <= next_iface_reset;
            cpu_shutdown <= next_cpu_shutdown;
            relay_energised <= next_relay_energised;
        end
    end
endmodule // dsw_supervisor

// ===== dsw_monitor.sv
`timescale 1ns/1ps
`include "dsw_defines.vh"
// ==========================================================
// port checker
module dsw_monitor
#(
    parameter CNT_W = `DSW_CNT_W
)
(
    input wire clk,
    input wire rst_n,
    input wire rti_pulse,
    input wire bg_cycle_end,
    input wire reset_cmd,
    input wire reinit_cmd,
    input wire [CNT_W-1:0] counter_reload_value,
    input wire [1:0] soft_trip_fault_code,
    input wire no_clock_flag,
    input wire soft_trip,
    input wire hard_trip,
    input wire motion_abort,
    input wire motor_kill,
    input wire motor_enable_allowed,
    input wire iface_reset,
    input wire cpu_shutdown,
    input wire relay_energised,
    input wire wd_toggle,
    input wire [CNT_W-1:0] service_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // empty counter while running, then the latched fault
    sequence s_zero_seen;
        motor_enable_allowed && service_count == 0 && !reset_cmd && !reinit_cmd;
    endsequence
    sequence s_bg_fault;
        soft_trip && soft_trip_fault_code == `DSW_FAULT_BG;
    endsequence
    // counter, reload and toggle
    a_count_dec: assert property (rti_pulse && !bg_cycle_end && service_count != 0 && !iface_reset
        |=> service_count == $past(service_count) - 1'b1) else $error("count did not step down");
    a_toggle_lsb: assert property (wd_toggle == service_count[0]) else $error("toggle not count lsb");
    a_reload_val: assert property (bg_cycle_end |=> service_count ==
        (($past(counter_reload_value) < `DSW_RELOAD_MIN) ? `DSW_RELOAD_DEFAULT : $past(counter_reload_value)))
        else $error("wrong reload");
    // trips and their outputs
    a_bg_trip: assert property (s_zero_seen |=> s_bg_fault) else $error("no trip at zero count");
    a_soft_outputs: assert property (soft_trip && $past(soft_trip) |-> motion_abort && motor_kill
        && iface_reset && !cpu_shutdown) else $error("soft trip outputs wrong");
    a_soft_hw_off: assert property (soft_trip && !hard_trip |=> !hard_trip) else $error("hard after soft");
    a_soft_hold: assert property (soft_trip && !reset_cmd && !reinit_cmd |=> soft_trip)
        else $error("soft trip released");
    a_alive_motors: assert property (no_clock_flag |-> !motor_enable_allowed) else $error("motors in alive");
    a_hard_outputs: assert property (hard_trip && $past(hard_trip) |-> cpu_shutdown && iface_reset
        && !relay_energised) else $error("hard trip outputs wrong");
    a_hard_latch: assert property (hard_trip |=> hard_trip) else $error("hard trip released");
endmodule // dsw_monitor

// ===== dsw_partner.sv
`timescale 1ns/1ps
// ==========================================================
// foreground interrupt and background loop model
module dsw_partner
(
    input wire clk,
    input wire run,
    input wire [15:0] rti_per,
    input wire [15:0] bg_per,
    output reg rti_pulse = 1'b0,
    output reg bg_cycle_end = 1'b0
);
    reg [15:0] cyc = 16'h0000;
    // one pulse per period, zero period stops that task
    always @(posedge clk)
    begin
        #1;
        cyc = cyc + 1'b1;
        rti_pulse = run && rti_per != 0 && cyc % rti_per == 0;
        bg_cycle_end = run && bg_per != 0 && cyc % bg_per == 0;
    end
endmodule // dsw_partner

// ===== tb_dual_stage_watchdog_supervisor.sv
`timescale 1ns/1ps
// ==========================================================
// testbench
module tb_dual_stage_watchdog_supervisor;
    reg clk, rst_n, clock_irq, undervolt, prun;
    reg [3:0] p;
    reg [15:0] reload, prti, pbg;
    reg [7:0] maxc;
    wire m_rti, m_bg, nclk, st, ht, ma, mk, me, ir, cs, rl, tg;
    wire [1:0] code;
    wire [15:0] cnt;
    integer err_count = 0;
    integer checks_done = 0;
    localparam RTI = 4'h1, BG = 4'h2, RST = 4'h4, INI = 4'h8;
    localparam logic [15:0] TBL [4] = '{16'h0063, 16'h0000, 16'h012c, 16'h0064};
    dsw_supervisor #(.TOGGLE_CYCLES(200), .CLKWAIT_CYCLES(50)) uut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .rti_pulse(p[0] | m_rti), .bg_cycle_end(p[1] | m_bg), .clock_irq(clock_irq), .reset_cmd(p[2]),
        .reinit_cmd(p[3]), .undervolt_pin(undervolt), .counter_reload_value(reload),
        .max_cycles_without_interrupt(maxc), .soft_trip_fault_code(code), .no_clock_flag(nclk), .soft_trip(st),
        .hard_trip(ht), .motion_abort(ma), .motor_kill(mk), .motor_enable_allowed(me), .iface_reset(ir),
        .cpu_shutdown(cs), .relay_energised(rl), .wd_toggle(tg), .service_count(cnt));
    dsw_partner sw (.clk(clk), .run(prun), .rti_per(prti), .bg_per(pbg), .rti_pulse(m_rti), .bg_cycle_end(m_bg));
    // clock and watchdog
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #500000;
        err_count = err_count + 1;
        results;
    end
    task step(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task pr(input [3:0] v);
        p = v;
        step(1);
        p = 4'h0;
        step(1);
    endtask
    task chk(input [19:0] got, input [19:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // main sequence
    initial
    begin
        rst_n = 1'b0; clock_irq = 1'b0; undervolt = 1'b0; prun = 1'b0; p = 4'h0;
        reload = 16'h0064; maxc = 8'h00; prti = 16'h0014; pbg = 16'h0096;
        step(4);
        rst_n = 1'b1;
        chk({code, rl, cnt}, 19'h01388);
        step(260);
        chk({nclk, me, ir, ht}, 4'h8);
        clock_irq = 1'b1;
        pr(RST);
        step(3);
        chk({nclk, me, ir, mk}, 4'h4);
        foreach (TBL[i])
        begin
            reload = TBL[i];
            pr(BG);
            chk(cnt, TBL[i] < 16'h0064 ? 16'h1388 : TBL[i]);
        end
        pr(RTI);
        chk({tg, cnt}, 17'h1_0063);
        repeat (99) pr(RTI);
        step(1);
        chk({st, code, ma, mk, ir, cs}, 7'h5e);
        pr(RTI);
        chk(cnt, 17'h0_0000);
        undervolt = 1'b1;
        step(10);
        chk(ht, 1'b0);
        undervolt = 1'b0;
        step(4);
        pr(BG);
        chk(st, 1'b1);
        pr(RST);
        chk(st, 1'b0);
        maxc = 8'h03;
        pr(RTI); pr(BG); pr(BG); pr(RTI); pr(BG); pr(BG);
        chk(st, 1'b0);
        pr(BG);
        chk({st, code}, 3'h6);
        pr(RTI); pr(INI);
        chk(st, 1'b0);
        maxc = 8'h00;
        prun = 1'b1;
        step(1000);
        chk({st, ht}, 2'h0);
        prti = 16'h012c;
        pbg = 16'h0000;
        step(700);
        chk({ht, cs, rl, ir}, 4'hd);
        prun = 1'b0;
        pr(RST); pr(INI);
        chk(ht, 1'b1);
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        step(60);
        chk({ht, me}, 2'h1);
        undervolt = 1'b1;
        step(6);
        chk({ht, rl}, 2'h2);
        results;
    end
endmodule // tb_dual_stage_watchdog_supervisor
bind dsw_supervisor dsw_monitor #(.CNT_W(CNT_W)) mon (.clk(clk), .rst_n(rst_n), .rti_pulse(rti_pulse),
    .bg_cycle_end(bg_cycle_end), .reset_cmd(reset_cmd), .reinit_cmd(reinit_cmd),
    .counter_reload_value(counter_reload_value), .soft_trip_fault_code(soft_trip_fault_code),
    .no_clock_flag(no_clock_flag), .soft_trip(soft_trip), .hard_trip(hard_trip), .motion_abort(motion_abort),
    .motor_kill(motor_kill), .motor_enable_allowed(motor_enable_allowed), .iface_reset(iface_reset),
    .cpu_shutdown(cpu_shutdown), .relay_energised(relay_energised), .wd_toggle(wd_toggle),
    .service_count(service_count));
